// ### rtl/eeprom_status_pkg.sv
/*
 * Constants for the serial EEPROM status and write-protection block.
 * Assumes a clocked SPI front end where the serial clock is sampled by clk_i.
 */
package eeprom_status_pkg;
    localparam logic [7:0] CMD_SET_LATCH = 8'h06;
    localparam logic [7:0] CMD_CLEAR_LATCH = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_WRITE = 8'h02;
    localparam logic [7:0] CMD_READ = 8'h03;
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_BP0 = 2;
    localparam int BIT_BP1 = 3;
    localparam int BIT_HWPEN = 7;
    localparam logic [5:0] BITS_CMD = 6'h08;
    localparam logic [5:0] BITS_ADDR_END = 6'h18;
    localparam logic [5:0] BITS_DATA = 6'h08;
    localparam logic [5:0] BITS_WSR_END = 6'h10;
    localparam logic [13:0] PROT_START_QUARTER = 14'h3000;
    localparam logic [13:0] PROT_START_HALF = 14'h2000;
    localparam logic [13:0] PROT_START_ALL = 14'h0000;
    localparam int unsigned WRITE_TIME_US = 5000;
    localparam int unsigned CLK_MHZ = 200;
    localparam int unsigned WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
endpackage

// ### rtl/eeprom_status_write_protect.sv
/*
 * Status register and write-protection logic of a serial EEPROM slave.
 * Assumes an SPI mode 0 host; the serial clock, select, data in and protect
 * pin are asynchronous and are synchronised into clk_i.
 */
// Functional notes
// [RULE1] Read-status answers the status byte at any time, even while busy.
// [RULE2] Bit 0 reads one while an internal write runs, else zero.
// [RULE3] Bit 1 mirrors the write-enable latch and is read-only.
// [RULE4] Set and clear latch commands always act, ignoring hardware protection.
// [RULE5] Bits 3 and 2 select protected blocks, changed only by write-status.
// [RULE6] Write-status changes only bit 7, bit 3 and bit 2.
// [RULE7] Protect codes: none, upper quarter, upper half, whole array.
// [RULE8] Array writes into the protected region are always refused.
// [RULE9] Hardware protection holds when pin is low and bit 7 is one.
// [RULE10] Hardware protection blocks only status writes, not unprotected array writes.
// [RULE11] With the latch clear no array or status write completes.
// [RULE12] A completed byte, page or status write clears the latch.
// [RULE13] Internal writes start only when select rises on a byte boundary.
// [RULE14] Array accesses during an internal write are ignored.
// [RULE15] After reset: standby, latch clear, data output not driven.
// [RULE16] Command codes 06h set latch, 04h clear latch, 05h read status.
// [RULE17] Everything shifts most significant bit first in eight-bit bytes.
// [RULE18] The latch sets only when select rises after all eight command bits.
// [RULE19] Bits 6 to 4 read as zero and are ignored on writes.
`timescale 1ns/10ps
`default_nettype none
module eeprom_status_write_protect #(
    parameter int unsigned WRITE_CYCLES = eeprom_status_pkg::WRITE_CYCLES
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic enable_i,
    input wire logic sck_i,
    input wire logic cs_n_i,
    input wire logic si_i,
    input wire logic wp_n_i,
    output logic so_o,
    output logic so_oe_o,
    output logic write_busy_flag_o,
    output logic array_write_o,
    output logic [13:0] array_addr_o,
    output logic [7:0] array_data_o
);
    typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_BODY} phase_t;
    phase_t phase;
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] si_s;
    logic [1:0] wp_s;
    logic [5:0] bit_cnt;
    logic [7:0] shift_in;
    logic [7:0] cmd;
    logic [7:0] out_byte;
    logic [13:0] addr;
    logic [7:0] page_data;
    logic page_valid;
    logic write_latch_flag;
    logic block_protect_sel0;
    logic block_protect_sel1;
    logic hw_protect_enable;
    logic [31:0] busy_cnt;
    logic pending_array;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic cs_fall;
    logic [7:0] next_shift;
    logic [7:0] status_byte;
    logic hw_protected;
    logic addr_protected;
    logic data_boundary;

    // Three flip-flops on sck and select, two on data in and protect; edge detection looks only at settled stages.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sck_s <= 3'h0;
            cs_s <= 3'h7;
            si_s <= 2'h0;
            wp_s <= 2'h3;
        end else if (enable_i) begin
            sck_s <= {sck_s[1:0], sck_i};
            cs_s <= {cs_s[1:0], cs_n_i};
            si_s <= {si_s[0], si_i};
            wp_s <= {wp_s[0], wp_n_i};
        end
    end

    // Edge strobes and protection decode.
    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];
    assign cs_rise = cs_s[1] & ~cs_s[2];
    assign cs_fall = ~cs_s[1] & cs_s[2];
    assign next_shift = {shift_in[6:0], si_s[1]}; // [RULE17]
    assign hw_protected = ~wp_s[1] & hw_protect_enable; // [RULE9]
    assign status_byte = {hw_protect_enable, 3'h0, block_protect_sel1, block_protect_sel0,
                          write_latch_flag, (busy_cnt != 32'h0)}; // [RULE2] [RULE3] [RULE19]
    assign data_boundary = (bit_cnt >= eeprom_status_pkg::BITS_ADDR_END)
        && (((bit_cnt - eeprom_status_pkg::BITS_ADDR_END) & 6'h07) == 6'h00)
        && (bit_cnt != eeprom_status_pkg::BITS_ADDR_END);

    // Region selected by the block-protect bits.
    always_comb begin
        case ({block_protect_sel1, block_protect_sel0}) // [RULE7]
            2'b01: addr_protected = addr >= eeprom_status_pkg::PROT_START_QUARTER;
            2'b10: addr_protected = addr >= eeprom_status_pkg::PROT_START_HALF;
            2'b11: addr_protected = addr >= eeprom_status_pkg::PROT_START_ALL;
            default: addr_protected = 1'b0;
        endcase
    end

    // Frame sequencing: command byte, then address and data bits.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phase <= ST_IDLE;
            bit_cnt <= 6'h00;
            shift_in <= 8'h00;
            cmd <= 8'h00;
            addr <= 14'h0000;
        end else if (enable_i) begin
            if (cs_s[1]) begin
                phase <= ST_IDLE;
                bit_cnt <= 6'h00;
            end else if (sck_rise) begin
                shift_in <= next_shift;
                bit_cnt <= bit_cnt + 6'h01;
                if (bit_cnt == eeprom_status_pkg::BITS_CMD - 6'h01) begin
                    cmd <= next_shift;
                    phase <= ST_BODY;
                end else if (bit_cnt == 6'h00) begin
                    phase <= ST_CMD;
                end
                if (bit_cnt > eeprom_status_pkg::BITS_CMD + 6'h01
                    && bit_cnt < eeprom_status_pkg::BITS_ADDR_END) begin
                    addr <= {addr[12:0], si_s[1]};
                end else if (data_boundary && page_valid) begin
                    addr <= addr + 14'h0001;
                end
            end
        end
    end

    // Last full data byte of a write frame; the page buffer itself lives in the array.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            page_data <= 8'h00;
            page_valid <= 1'b0;
        end else if (enable_i) begin
            if (cs_fall) begin
                page_valid <= 1'b0;
            end else if (!cs_s[1] && sck_rise && cmd == eeprom_status_pkg::CMD_WRITE
                         && phase == ST_BODY
                         && bit_cnt >= eeprom_status_pkg::BITS_ADDR_END
                             + eeprom_status_pkg::BITS_DATA - 6'h01
                         && (bit_cnt & (eeprom_status_pkg::BITS_DATA - 6'h01))
                             == eeprom_status_pkg::BITS_DATA - 6'h01) begin
                page_data <= next_shift;
                page_valid <= 1'b1;
            end
        end
    end

    // Latch, nonvolatile bits and internal write timer, acting on select rising.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            write_latch_flag <= 1'b0; // [RULE15]
            block_protect_sel0 <= 1'b0;
            block_protect_sel1 <= 1'b0;
            hw_protect_enable <= 1'b0;
            busy_cnt <= 32'h0;
            pending_array <= 1'b0;
        end else if (enable_i) begin
            if (busy_cnt != 32'h0) begin
                busy_cnt <= busy_cnt - 32'h1;
                if (busy_cnt == 32'h1) begin
                    pending_array <= 1'b0;
                    write_latch_flag <= 1'b0; // [RULE12]
                end
            end
            if (cs_rise && phase == ST_BODY) begin
                if (cmd == eeprom_status_pkg::CMD_SET_LATCH
                    && bit_cnt == eeprom_status_pkg::BITS_CMD) begin
                    write_latch_flag <= 1'b1; // [RULE4] [RULE16] [RULE18]
                end else if (cmd == eeprom_status_pkg::CMD_CLEAR_LATCH
                             && bit_cnt == eeprom_status_pkg::BITS_CMD) begin
                    write_latch_flag <= 1'b0; // [RULE4] [RULE16]
                end else if (busy_cnt == 32'h0 && write_latch_flag) begin // [RULE11] [RULE14]
                    if (cmd == eeprom_status_pkg::CMD_WRITE_STATUS
                        && bit_cnt == eeprom_status_pkg::BITS_WSR_END
                        && !hw_protected) begin // [RULE10] [RULE13]
                        hw_protect_enable <= shift_in[eeprom_status_pkg::BIT_HWPEN]; // [RULE6]
                        block_protect_sel1 <= shift_in[eeprom_status_pkg::BIT_BP1]; // [RULE5]
                        block_protect_sel0 <= shift_in[eeprom_status_pkg::BIT_BP0];
                        busy_cnt <= WRITE_CYCLES;
                    end else if (cmd == eeprom_status_pkg::CMD_WRITE && page_valid
                                 && data_boundary && !addr_protected) begin // [RULE8] [RULE13]
                        busy_cnt <= WRITE_CYCLES;
                        pending_array <= 1'b1;
                    end
                end
            end
        end
    end

    // Array write strobe issued once the frame has been accepted.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            array_write_o <= 1'b0;
            array_addr_o <= 14'h0000;
            array_data_o <= 8'h00;
            write_busy_flag_o <= 1'b0;
        end else if (enable_i) begin
            // Fires in the cycle after the timer is loaded, so exactly once per commit.
            array_write_o <= pending_array && busy_cnt == WRITE_CYCLES; // [RULE13]
            array_addr_o <= addr;
            array_data_o <= page_data;
            write_busy_flag_o <= busy_cnt != 32'h0; // [RULE2]
        end
    end

    // Status byte shifted out on falling serial clock during read-status.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            so_o <= 1'b0;
            so_oe_o <= 1'b0; // [RULE15]
            out_byte <= 8'h00;
        end else if (enable_i) begin
            if (cs_s[1]) begin
                so_oe_o <= 1'b0;
            end else if (sck_fall && phase == ST_BODY
                         && cmd == eeprom_status_pkg::CMD_READ_STATUS) begin // [RULE1]
                if (bit_cnt[2:0] == 3'h0) begin
                    so_o <= status_byte[7];
                    out_byte <= {status_byte[6:0], 1'b0};
                end else begin
                    so_o <= out_byte[7];
                    out_byte <= {out_byte[6:0], 1'b0};
                end
                so_oe_o <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb/eeprom_status_write_protect_sva.sv
/* Port checker for the status and write-protect block.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/10ps
`default_nettype none
module eeprom_status_write_protect_sva #(
    parameter int unsigned WRITE_CYCLES = 50
) (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic so_o,
    input wire logic so_oe_o,
    input wire logic write_busy_flag_o,
    input wire logic array_write_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!resetn_i);
    int unsigned busy_len;
    // Counts how long the busy flag has stood, so its length can be judged.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_len <= 0;
        end else begin
            busy_len <= write_busy_flag_o ? busy_len + 1 : 0;
        end
    end
    a_reset_quiet: assert property ($rose(resetn_i) |-> !so_oe_o && !write_busy_flag_o)
        else $error("outputs active after reset");
    a_oe_idle: assert property (cs_n_i [*8] |-> !so_oe_o)
        else $error("so driven while deselected");
    a_commit_once: assert property (array_write_o |=> !array_write_o [*8])
        else $error("second commit during write");
    a_commit_busy: assert property (array_write_o |-> ##[0:4] write_busy_flag_o)
        else $error("commit without write cycle");
    a_commit_deselect: assert property (!cs_n_i [*8] |-> !array_write_o)
        else $error("commit while selected");
    a_busy_bound: assert property (busy_len <= WRITE_CYCLES + 2)
        else $error("busy too long");
    a_busy_length: assert property ($fell(write_busy_flag_o) |-> busy_len + 2 >= WRITE_CYCLES)
        else $error("busy too short");
    a_so_on_fall: assert property (so_oe_o && $changed(so_o) |-> !sck_i)
        else $error("so changed with sck high");
    cover property (so_oe_o && write_busy_flag_o);
    cover property (array_write_o);
    cover property ($fell(write_busy_flag_o));
    cover property (so_oe_o && sck_i);
endmodule
bind eeprom_status_write_protect eeprom_status_write_protect_sva #(
    .WRITE_CYCLES(WRITE_CYCLES)
) chk (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n_i(cs_n_i), .sck_i(sck_i), .so_o(so_o),
    .so_oe_o(so_oe_o), .write_busy_flag_o(write_busy_flag_o), .array_write_o(array_write_o));
`default_nettype wire

// ### tb/spi_host_model.sv
/* Behavioural SPI mode 0 host that frames commands for the block.
   Assumes the bench clock; sck period is 32 clock cycles. */
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input wire logic clk_i,
    input wire logic so_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic si_o
);
    // Deselected with sck parked low outside frames.
    initial begin
        cs_n_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end
    // Waits half an sck period on falling clock edges.
    task automatic half;
        repeat (16) @(negedge clk_i);
    endtask
    // Shifts n bits from the top of d, keeping the last eight so bits.
    task automatic xfer(input int n, input logic [31:0] d, output logic [7:0] q);
        q = 8'h00;
        cs_n_o = 1'b0;
        for (int i = 0; i < n; i++) begin
            si_o = d[31-i];
            half();
            sck_o = 1'b1;
            q = {q[6:0], so_i};
            half();
            sck_o = 1'b0;
        end
        half();
        cs_n_o = 1'b1;
        si_o = ~si_o;
        half();
        half();
    endtask
endmodule
`default_nettype wire

// ### tb/tb_eeprom_status_write_protect.sv
/* Self-checking bench for the status and write-protect block.
   Assumes the host model and checker files are compiled with it. */
`timescale 1ns/10ps
`default_nettype none
module tb_eeprom_status_write_protect;
    localparam int unsigned WC = 2000;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic wp_n_i = 1'b1;
    logic cs_n, sck, si, so, so_oe, busy, aw;
    logic so_line;
    logic [13:0] aa, wa;
    logic [7:0] ad, wd, q;
    logic [23:0] nwr = 24'h0;
    int errors = 0;
    int checks_done = 0;
    always #2.5 clk_i = ~clk_i;
    eeprom_status_write_protect #(.WRITE_CYCLES(WC)) dut (.clk_i(clk_i), .resetn_i(resetn_i),
        .enable_i(1'b1), .sck_i(sck), .cs_n_i(cs_n), .si_i(si), .wp_n_i(wp_n_i), .so_o(so),
        .so_oe_o(so_oe), .write_busy_flag_o(busy), .array_write_o(aw), .array_addr_o(aa),
        .array_data_o(ad));
    // A released data line reads as the inverse of the last bit, so stale data cannot pass.
    assign so_line = so_oe ? so : ~so;
    spi_host_model host (.clk_i(clk_i), .so_i(so_line), .cs_n_o(cs_n), .sck_o(sck), .si_o(si));
    // Records every array commit with its address and data.
    always @(posedge clk_i) begin
        if (aw === 1'b1) begin
            nwr++;
            wa = aa;
            wd = ad;
        end
    end
    task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cmd(input logic [7:0] c);
        host.xfer(8, {c, 24'h0}, q);
    endtask
    task automatic read_status_cmd(input logic [7:0] e);
        host.xfer(16, {8'h05, 24'h0}, q);
        chk(q, e);
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input int n);
        host.xfer(n, {8'h02, a, d}, q);
    endtask
    // Bounded wait for the internal write timer to run out.
    task automatic settle;
        for (int i = 0; i < WC + 100 && busy !== 1'b0; i++) begin
            @(negedge clk_i);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // The tests need about 23k cycles; the limit of 80k cycles allows more than three times that.
    initial begin
        #400000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (6) @(negedge clk_i);
        resetn_i = 1'b1;
        chk(so_oe, 1'b0);
        read_status_cmd(8'h00);
        cmd(8'h06);
        read_status_cmd(8'h02);
        cmd(8'h04);
        read_status_cmd(8'h00);
        host.xfer(16, 32'h0600_0000, q);
        read_status_cmd(8'h00);
        $display("latch test done");
        cmd(8'h06);
        host.xfer(16, 32'h01fc_0000, q);
        chk(busy, 1'b1);
        read_status_cmd(8'h8f);
        settle();
        read_status_cmd(8'h8c);
        $display("status write test done");
        wp_n_i = 1'b0;
        cmd(8'h06);
        host.xfer(16, 32'h0100_0000, q);
        chk(busy, 1'b0);
        read_status_cmd(8'h8e);
        wr(16'h0000, 8'h5a, 32);
        chk(nwr, 24'h0);
        wp_n_i = 1'b1;
        cmd(8'h06);
        host.xfer(16, 32'h0184_0000, q);
        settle();
        read_status_cmd(8'h84);
        $display("protect test done");
        // Hardware protection stays on for the array tests: it must not block array writes.
        wp_n_i = 1'b0;
        cmd(8'h06);
        wr(16'h2fff, 8'ha5, 32);
        chk(nwr, 24'h1);
        chk({wa, wd}, {14'h2fff, 8'ha5});
        wr(16'h0100, 8'h11, 32);
        chk(nwr, 24'h1);
        settle();
        wr(16'h0100, 8'h11, 32);
        chk(nwr, 24'h1);
        cmd(8'h06);
        wr(16'h3000, 8'h22, 32);
        chk(nwr, 24'h1);
        wr(16'h0100, 8'h33, 28);
        chk(nwr, 24'h1);
        wr(16'hc100, 8'h3c, 32);
        chk(nwr, 24'h2);
        chk({wa, wd}, {14'h0100, 8'h3c});
        settle();
        read_status_cmd(8'h84);
        $display("array test done");
        wrap_up();
    end
endmodule
`default_nettype wire
